// ==== include/tmr_params.svh ====
// Offsets, field positions, reset values and timing figures of the triple timer
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH
// Clock rate and period
`define TMR_CLK_MHZ 40
`define TMR_CLK_PERIOD_NS 25
// Register window base (16-bit word address) and size in words
`define TMR_BASE_ADDR 16'h0C00
`define TMR_WIN_WORDS 6'h18
// Word index of each timer slot inside the window
`define TMR_SLOT0 6'h00
`define TMR_SLOT1 6'h08
`define TMR_SLOT2 6'h10
// Word offsets inside a slot
`define TMR_W_CNT_LO 3'h0
`define TMR_W_CNT_HI 3'h1
`define TMR_W_PRD_LO 3'h2
`define TMR_W_PRD_HI 3'h3
`define TMR_W_TCR 3'h4
`define TMR_W_RSVD 3'h5
`define TMR_W_TPR_LO 3'h6
`define TMR_W_TPR_HI 3'h7
// Control word fields
`define TMR_TCR_ROUTE_BIT 0
`define TMR_TCR_STOP_BIT 4
`define TMR_TCR_RELOAD_BIT 5
`define TMR_TCR_IE_BIT 14
`define TMR_TCR_FLAG_BIT 15
`define TMR_TCR_WMASK 16'h4011
// Reset values
`define TMR_TCR_RST 16'h4000
`define TMR_PRD_RST 32'hFFFFFFFF
`define TMR_CNT_RST 32'hFFFFFFFF
`define TMR_TPR_RST 16'h0000
`endif

// ==== include/tmr_pkg.sv ====
// Types and shared arithmetic of the triple timer
package tmr_pkg;
   typedef logic [31:0] tmr_word_t;   // Counter and period width
   typedef logic [15:0] tmr_half_t;   // Bus word and prescaler width
   typedef logic [2:0] tmr_slot_t;    // Word offset inside a slot

   // Prescaler start value: divide by the programmed value, zero acts as one
   function automatic tmr_half_t tmr_psc_load(input tmr_half_t div);
      tmr_psc_load = (div == 16'h0000) ? 16'h0000 : div - 16'h0001;
   endfunction : tmr_psc_load
endpackage : tmr_pkg

// ==== rtl/tmr_channel.sv ====
// One 32-bit down counter with 16-bit prescaler, period and control words
`timescale 1ns/10ps
`include "tmr_params.svh"
module tmr_channel (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic wr_en_i,
   input wire tmr_pkg::tmr_slot_t wr_word_i,
   input wire tmr_pkg::tmr_half_t wr_data_i,
   output tmr_pkg::tmr_word_t cnt_o,
   output tmr_pkg::tmr_word_t prd_o,
   output tmr_pkg::tmr_half_t tpr_o,
   output tmr_pkg::tmr_half_t psc_o,
   output tmr_pkg::tmr_half_t ctl_o,
   output logic irq_o
);
   import tmr_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // State
   tmr_word_t cnt, next_cnt;   // Down counter
   tmr_word_t prd, next_prd;   // Period
   tmr_half_t tpr, next_tpr;   // Programmed divider
   tmr_half_t psc, next_psc;   // Prescaler count
   tmr_half_t ctl, next_ctl;   // Control word
   logic irq, next_irq;        // Interrupt pulse
   logic run;                  // Not stopped
   logic tick;                 // Prescaler underflow
   logic zero;                 // Counter at zero
   logic reload_req;           // Software reload strobe

   assign cnt_o = cnt;
   assign prd_o = prd;
   assign tpr_o = tpr;
   assign psc_o = psc;
   assign ctl_o = ctl;
   assign irq_o = irq;

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      run = !ctl[`TMR_TCR_STOP_BIT];
      tick = run && (psc == 16'h0000);
      zero = (cnt == 32'h00000000);
      reload_req = wr_en_i && (wr_word_i == `TMR_W_TCR) && wr_data_i[`TMR_TCR_RELOAD_BIT];
      next_cnt = cnt;
      next_prd = prd;
      next_tpr = tpr;
      next_psc = psc;
      next_ctl = ctl;
      // Software writes; counter words are read only
      if (wr_en_i)
      begin
         case (wr_word_i)
            `TMR_W_PRD_LO: next_prd[15:0] = wr_data_i;
            `TMR_W_PRD_HI: next_prd[31:16] = wr_data_i;
            `TMR_W_TPR_LO: next_tpr = wr_data_i;
            `TMR_W_TCR:
            begin
               next_ctl = (ctl & ~`TMR_TCR_WMASK) | (wr_data_i & `TMR_TCR_WMASK);
               // Write one clears the zero flag
               if (wr_data_i[`TMR_TCR_FLAG_BIT])
                  next_ctl[`TMR_TCR_FLAG_BIT] = 1'b0;
            end
            default: next_ctl = next_ctl;
         endcase
      end
      // Prescaler counts down each system clock
      if (run)
      begin
         if (tick)
         begin
            next_psc = tmr_psc_load(tpr);
            // Decrement, or reload the period at zero
            if (zero)
               next_cnt = prd;
            else
               next_cnt = cnt - 32'h00000001;
         end
         else
            next_psc = psc - 16'h0001;
      end
      // Expiry sets the flag; set wins over a clear
      if (tick && zero)
         next_ctl[`TMR_TCR_FLAG_BIT] = 1'b1;
      // Software reload of counter and prescaler
      if (reload_req)
      begin
         next_cnt = prd;
         next_psc = tmr_psc_load(tpr);
      end
      // A zero period at divide by one expires every cycle; skip a cycle so the line still pulses
      next_irq = tick && zero && ctl[`TMR_TCR_IE_BIT] && !irq;
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers, all on the one system clock
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         cnt <= `TMR_CNT_RST;
         prd <= `TMR_PRD_RST;
         tpr <= `TMR_TPR_RST;
         psc <= `TMR_TPR_RST;
         ctl <= `TMR_TCR_RST;
         irq <= 1'b0;
      end
      else
      begin
         cnt <= next_cnt;
         prd <= next_prd;
         tpr <= next_tpr;
         psc <= next_psc;
         ctl <= next_ctl;
         irq <= next_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);

   sequence s_expire;
      tick && zero && !reload_req;
   endsequence

   property p_reload;
      s_expire |=> (cnt == $past(prd));
   endproperty
   a_reload: assert property (p_reload) else $error("counter missed period reload");

   property p_count;
      tick && !zero && !reload_req |=> (cnt == $past(cnt) - 32'h00000001);
   endproperty
   a_count: assert property (p_count) else $error("counter did not decrement");

   property p_prescale;
      run && (psc != 16'h0000) && !reload_req && !wr_en_i |=> (psc == $past(psc) - 16'h0001) && $stable(cnt);
   endproperty
   a_prescale: assert property (p_prescale) else $error("counter moved between prescaler ticks");

   property p_psc_load;
      tick |=> (psc == tmr_psc_load($past(tpr)));
   endproperty
   a_psc_load: assert property (p_psc_load) else $error("prescaler not reloaded on underflow");

   property p_irq_cause;
      irq |-> $past(tick) && $past(zero) && $past(ctl[`TMR_TCR_IE_BIT]);
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("interrupt without expiry");

   property p_pulse;
      irq |=> !irq;
   endproperty
   a_pulse: assert property (p_pulse) else $error("interrupt held longer than one cycle");
endmodule : tmr_channel

// ==== rtl/tmr_top.sv ====
// Three 32-bit CPU timers with word register port and interrupt routing
//
// Functional notes
// - Three identical timers, 32-bit counter, 16-bit prescaler
// - Counter counts down, interrupt at zero
// - Decrement rate is clock over prescale
// - Automatic period reload on reaching zero
// - Timer 2 drives CPU line fourteen
// - Timer 1 connectable to CPU line thirteen
// - Timer 0 feeds the interrupt expansion block
// - Interrupt output is a single pulse
// - Eight-word register slot per timer
// - Everything runs on the system clock
`timescale 1ns/10ps
`include "tmr_params.svh"
module tmr_top (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic bus_sel_i,
   input wire logic bus_we_i,
   input wire tmr_pkg::tmr_half_t bus_addr_i,
   input wire tmr_pkg::tmr_half_t bus_wdata_i,
   output tmr_pkg::tmr_half_t bus_rdata_o,
   output logic bus_ack_o,
   output logic interrupt_expansion_block_o,
   output logic cpu_irq_line_thirteen_o,
   output logic cpu_irq_line_fourteen_o
);
   import tmr_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Decode and per-timer views
   logic hit;                 // Access inside the timer window
   logic [5:0] idx;           // Word index inside the window
   logic [1:0] sel_tmr;       // Timer number of the access
   tmr_slot_t word;           // Word inside the slot
   logic [2:0] wr_en;         // Write strobe per timer
   tmr_word_t cnt_a [3];      // Counters
   tmr_word_t prd_a [3];      // Periods
   tmr_half_t tpr_a [3];      // Dividers
   tmr_half_t psc_a [3];      // Prescaler counts
   tmr_half_t ctl_a [3];      // Control words
   logic [2:0] irq_a;         // Raw interrupt pulses

   // Output registers
   tmr_half_t rdata, next_rdata;
   logic ack, next_ack;
   logic irq_exp, next_irq_exp;
   logic irq13, next_irq13;
   logic irq14, next_irq14;

   assign bus_rdata_o = rdata;
   assign bus_ack_o = ack;
   assign interrupt_expansion_block_o = irq_exp;
   assign cpu_irq_line_thirteen_o = irq13;
   assign cpu_irq_line_fourteen_o = irq14;

   ////////////////////////////////////////////////////////////////////////
   // Read value of one word of a slot
   function automatic tmr_half_t rd_word(input tmr_slot_t w, input tmr_word_t c, input tmr_word_t p,
                                         input tmr_half_t t, input tmr_half_t s, input tmr_half_t k);
      case (w)
         `TMR_W_CNT_LO: rd_word = c[15:0];
         `TMR_W_CNT_HI: rd_word = c[31:16];
         `TMR_W_PRD_LO: rd_word = p[15:0];
         `TMR_W_PRD_HI: rd_word = p[31:16];
         `TMR_W_TCR: rd_word = k;
         `TMR_W_TPR_LO: rd_word = t;
         `TMR_W_TPR_HI: rd_word = s;
         default: rd_word = 16'h0000;
      endcase
   endfunction : rd_word

   ////////////////////////////////////////////////////////////////////////
   // Address decode
   always_comb
   begin
      // Upper ten address bits pick the window
      hit = bus_sel_i && (bus_addr_i[15:6] == 10'(`TMR_BASE_ADDR >> 6));
      idx = bus_addr_i[5:0];
      sel_tmr = idx[4:3];
      word = idx[2:0];
      // Slots at 0x00, 0x08, 0x10; above the window is unmapped
      wr_en[0] = hit && bus_we_i && (idx[5:3] == 3'(`TMR_SLOT0 >> 3));
      wr_en[1] = hit && bus_we_i && (idx[5:3] == 3'(`TMR_SLOT1 >> 3));
      wr_en[2] = hit && bus_we_i && (idx[5:3] == 3'(`TMR_SLOT2 >> 3));
   end

   ////////////////////////////////////////////////////////////////////////
   // Three identical timers
   for (genvar g = 0; g < 3; g++)
   begin : g_tmr
      tmr_channel u_chan (
         .clock_i(clock_i),
         .srst_i(srst_i),
         .wr_en_i(wr_en[g]),
         .wr_word_i(word),
         .wr_data_i(bus_wdata_i),
         .cnt_o(cnt_a[g]),
         .prd_o(prd_a[g]),
         .tpr_o(tpr_a[g]),
         .psc_o(psc_a[g]),
         .ctl_o(ctl_a[g]),
         .irq_o(irq_a[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data, acknowledge and interrupt routing
   always_comb
   begin
      next_ack = bus_sel_i;
      next_rdata = 16'h0000;
      // Unmapped words read as zero
      if (hit && !bus_we_i && (idx < `TMR_WIN_WORDS))
      begin
         case (sel_tmr)
            2'h0: next_rdata = rd_word(word, cnt_a[0], prd_a[0], tpr_a[0], psc_a[0], ctl_a[0]);
            2'h1: next_rdata = rd_word(word, cnt_a[1], prd_a[1], tpr_a[1], psc_a[1], ctl_a[1]);
            2'h2: next_rdata = rd_word(word, cnt_a[2], prd_a[2], tpr_a[2], psc_a[2], ctl_a[2]);
            default: next_rdata = 16'h0000;
         endcase
      end
      next_irq_exp = irq_a[0];
      next_irq13 = irq_a[1] && ctl_a[1][`TMR_TCR_ROUTE_BIT];
      next_irq14 = irq_a[2];
   end

   // Output flip-flops
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         rdata <= 16'h0000;
         ack <= 1'b0;
         irq_exp <= 1'b0;
         irq13 <= 1'b0;
         irq14 <= 1'b0;
      end
      else
      begin
         rdata <= next_rdata;
         ack <= next_ack;
         irq_exp <= next_irq_exp;
         irq13 <= next_irq13;
         irq14 <= next_irq14;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);

   sequence s_rd_prd0;
      bus_sel_i && !bus_we_i && (bus_addr_i == `TMR_BASE_ADDR + 16'h0002);
   endsequence

   property p_route14;
      irq_a[2] |=> cpu_irq_line_fourteen_o ##1 !cpu_irq_line_fourteen_o;
   endproperty
   a_route14: assert property (p_route14) else $error("timer 2 pulse missing on line fourteen");

   property p_route13;
      cpu_irq_line_thirteen_o |-> $past(irq_a[1]) && $past(ctl_a[1][`TMR_TCR_ROUTE_BIT]);
   endproperty
   a_route13: assert property (p_route13) else $error("line thirteen pulse without timer 1");

   property p_expansion;
      irq_a[0] |=> interrupt_expansion_block_o ##1 !interrupt_expansion_block_o;
   endproperty
   a_expansion: assert property (p_expansion) else $error("timer 0 pulse missing at expansion block");

   property p_single_pulse;
      interrupt_expansion_block_o |=> !interrupt_expansion_block_o;
   endproperty
   a_single_pulse: assert property (p_single_pulse) else $error("expansion interrupt not a pulse");

   property p_rd_period;
      s_rd_prd0 |=> bus_ack_o && (bus_rdata_o == $past(prd_a[0][15:0]));
   endproperty
   a_rd_period: assert property (p_rd_period) else $error("period low word read wrong");

   // Control word of timer 2 read back through its slot
   sequence s_rd_ctl2;
      bus_sel_i && !bus_we_i && (bus_addr_i == `TMR_BASE_ADDR + 16'h0014);
   endsequence

   property p_rd_ctl2;
      s_rd_ctl2 |=> bus_ack_o && (bus_rdata_o == $past(ctl_a[2]));
   endproperty
   a_rd_ctl2: assert property (p_rd_ctl2) else $error("timer 2 control read wrong");

   // Every request is answered on the next cycle
   property p_ack;
      bus_sel_i |=> bus_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("bus request not acknowledged");

   // No request, no answer and no data
   property p_idle;
      !bus_sel_i |=> !bus_ack_o && (bus_rdata_o == 16'h0000);
   endproperty
   a_idle: assert property (p_idle) else $error("bus answer without request");

   // Words past the three slots read as zero
   property p_unmapped;
      hit && !bus_we_i && (idx >= `TMR_WIN_WORDS) |=> (bus_rdata_o == 16'h0000);
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped word read nonzero");

   // Writes return no data
   property p_wr_rdata;
      bus_sel_i && bus_we_i |=> (bus_rdata_o == 16'h0000);
   endproperty
   a_wr_rdata: assert property (p_wr_rdata) else $error("write returned read data");

   // Lines thirteen and fourteen carry pulses, never levels
   property p_pulse13;
      cpu_irq_line_thirteen_o |=> !cpu_irq_line_thirteen_o;
   endproperty
   a_pulse13: assert property (p_pulse13) else $error("line thirteen not a pulse");

   property p_pulse14;
      cpu_irq_line_fourteen_o |=> !cpu_irq_line_fourteen_o;
   endproperty
   a_pulse14: assert property (p_pulse14) else $error("line fourteen not a pulse");
endmodule : tmr_top

// ==== verification/tmr_irq_sink.sv ====
// Model of the interrupt receivers on the three timer lines
`timescale 1ns/10ps
module tmr_irq_sink (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic [2:0] irq_i,
   output logic [2:0][31:0] cnt_o,
   output logic [2:0][31:0] last_o,
   output logic [2:0][31:0] prev_o,
   output logic wide_o
);
   logic [31:0] now; // Free cycle count
   logic [2:0] irq_q; // Lines one cycle ago

   //////////////////////////////////////////////////////////////////////////
   // Stamp each rising edge, flag a line held high two cycles in a row
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         now <= 32'h0;
         irq_q <= 3'h0;
         wide_o <= 1'b0;
         cnt_o <= '0;
         last_o <= '0;
         prev_o <= '0;
      end
      else
      begin
         now <= now + 32'h1;
         irq_q <= irq_i;
         wide_o <= wide_o | (|(irq_i & irq_q));
         for (int i = 0; i < 3; i++)
         begin
            if (irq_i[i] && !irq_q[i])
            begin
               cnt_o[i] <= cnt_o[i] + 32'h1;
               prev_o[i] <= last_o[i];
               last_o[i] <= now;
            end
         end
      end
   end
endmodule : tmr_irq_sink

// ==== verification/tmr_top_tb.sv ====
// Self-checking bench for the triple timer
`timescale 1ns/10ps
module tmr_top_tb;
   import tmr_pkg::*;
   logic clock_i, srst_i, bus_sel_i, bus_we_i; // Clock, reset, bus strobes
   tmr_half_t bus_addr_i, bus_wdata_i, bus_rdata_o, rd; // Bus words
   logic bus_ack_o, irq0, irq1, irq2; // Design answers
   logic [2:0][31:0] cnt, last, prev; // Receiver stamps
   logic wide; // Over-long pulse seen
   int num_errors = 0;
   int checked = 0;

   //////////////////////////////////////////////////////////////////////////
   // Clock at 40 MHz
   initial
   begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end

   tmr_top DUT (.clock_i(clock_i), .srst_i(srst_i), .bus_sel_i(bus_sel_i), .bus_we_i(bus_we_i),
      .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o),
      .bus_ack_o(bus_ack_o), .interrupt_expansion_block_o(irq0), .cpu_irq_line_thirteen_o(irq1),
      .cpu_irq_line_fourteen_o(irq2));

   tmr_irq_sink SINK (.clock_i(clock_i), .srst_i(srst_i), .irq_i({irq2, irq1, irq0}),
      .cnt_o(cnt), .last_o(last), .prev_o(prev), .wide_o(wide));

   //////////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic test_done();
      $display("Comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : test_done

   // Compare one value and count it
   task automatic check(input string what, input tmr_word_t exp, input tmr_word_t got);
      checked++;
      if (got !== exp)
      begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         num_errors++;
      end
   endtask : check

   // One bus access: request held up to the edge that samples the answer
   task automatic bus(input logic we, input tmr_half_t addr, input tmr_half_t data);
      int n;
      logic ack;
      @(posedge clock_i);
      bus_sel_i <= 1'b1;
      bus_we_i <= we;
      bus_addr_i <= addr;
      bus_wdata_i <= data;
      n = 0;
      ack = 1'b0;
      // Outputs are flops: the falling-edge value is what the next rising edge samples
      while (ack !== 1'b1 && n < 8)
      begin
         @(negedge clock_i);
         ack = bus_ack_o;
         rd = bus_rdata_o;
         n++;
      end
      @(posedge clock_i);
      bus_sel_i <= 1'b0;
      check("ack", 32'h1, {31'h0, ack});
      check("ack delay", 32'd2, 32'(n));
      if (ack !== 1'b1)
         test_done();
   endtask : bus

   // Read a word and compare it
   task automatic rchk(input string what, input tmr_half_t addr, input tmr_half_t exp);
      bus(1'b0, addr, 16'h0000);
      check(what, {16'h0000, exp}, {16'h0000, rd});
   endtask : rchk

   // Wait three pulses on a line, compare the last spacing
   task automatic interval(input int idx, input tmr_word_t exp);
      logic [31:0] c;
      c = cnt[idx];
      for (int n = 0; n < 200 && cnt[idx] < c + 32'h3; n++)
         @(posedge clock_i);
      if (cnt[idx] < c + 32'h3)
      begin
         $display("CHECK FAILED pulses on line %0d expected 3 seen fewer", idx);
         num_errors++;
         test_done();
      end
      check("interval", exp, last[idx] - prev[idx]);
   endtask : interval

   // Count pulses on a line over 40 cycles, expect none
   task automatic quiet(input int idx);
      logic [31:0] c;
      // Let a pulse already in flight reach the receiver first
      repeat (4) @(posedge clock_i);
      c = cnt[idx];
      repeat (40) @(posedge clock_i);
      check("quiet line", c, cnt[idx]);
   endtask : quiet

   //////////////////////////////////////////////////////////////////////////
   // Reset values, reserved and unmapped words
   task automatic t_reset();
      for (int t = 0; t < 3; t++)
      begin
         rchk("control", 16'h0C04 + 16'(8 * t), 16'h4000);
         rchk("period hi", 16'h0C03 + 16'(8 * t), 16'hFFFF);
         rchk("divider", 16'h0C06 + 16'(8 * t), 16'h0000);
         rchk("reserved", 16'h0C05 + 16'(8 * t), 16'h0000);
      end
      rchk("count hi", 16'h0C11, 16'hFFFF);
      rchk("unmapped", 16'h0C18, 16'h0000);
      rchk("unmapped", 16'h0C3F, 16'h0000);
   endtask : t_reset

   // Timer 0 period reload, pulse spacing and width
   task automatic t_period();
      bus(1'b1, 16'h0C02, 16'h0005);
      bus(1'b1, 16'h0C03, 16'h0000);
      bus(1'b1, 16'h0C04, 16'h4020);
      rchk("period lo", 16'h0C02, 16'h0005);
      interval(0, 32'd6);
      check("single pulse", 32'h0, {31'h0, wide});
   endtask : t_period

   // Timer 2 prescaler at several dividers
   task automatic t_prescale();
      tmr_half_t d [3] = '{16'h0000, 16'h0001, 16'h0003};
      bus(1'b1, 16'h0C12, 16'h0004);
      bus(1'b1, 16'h0C13, 16'h0000);
      for (int i = 0; i < 3; i++)
      begin
         bus(1'b1, 16'h0C16, d[i]);
         bus(1'b1, 16'h0C14, 16'h4020);
         rchk("divider", 16'h0C16, d[i]);
         interval(2, 32'd5 * ((d[i] > 16'h1) ? 32'(d[i]) : 32'h1));
      end
   endtask : t_prescale

   // Timer 1 reaches line 13 only with its route bit
   task automatic t_route();
      bus(1'b1, 16'h0C0A, 16'h0002);
      bus(1'b1, 16'h0C0B, 16'h0000);
      bus(1'b1, 16'h0C0C, 16'h4020);
      quiet(1);
      bus(1'b1, 16'h0C0C, 16'h4001);
      interval(1, 32'd3);
   endtask : t_route

   // Masked expiry, flag clear, stop, read-only counter, down count
   task automatic t_mask_stop();
      tmr_half_t a;
      bus(1'b1, 16'h0C14, 16'h0000);
      quiet(2);
      rchk("zero flag", 16'h0C14, 16'h8000);
      bus(1'b1, 16'h0C12, 16'h0100);
      bus(1'b1, 16'h0C16, 16'h0000);
      bus(1'b1, 16'h0C14, 16'h0030);
      bus(1'b1, 16'h0C14, 16'h8010);
      rchk("control", 16'h0C14, 16'h0010);
      bus(1'b1, 16'h0C10, 16'h0007);
      rchk("stopped count", 16'h0C10, 16'h0100);
      bus(1'b1, 16'h0C14, 16'h0000);
      bus(1'b0, 16'h0C10, 16'h0000);
      a = rd;
      check("count down", 32'h1, {31'h0, (a < 16'h0100) && (a > 16'h00F0)});
   endtask : t_mask_stop

   //////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      srst_i = 1'b1;
      bus_sel_i = 1'b0;
      bus_we_i = 1'b0;
      bus_addr_i = 16'h0000;
      bus_wdata_i = 16'h0000;
      repeat (16) @(posedge clock_i);
      check("lines in reset", 32'h0, {29'h0, irq2, irq1, irq0});
      srst_i <= 1'b0;
      t_reset();
      t_period();
      t_prescale();
      t_route();
      t_mask_stop();
      test_done();
   end
endmodule : tmr_top_tb
